// ===== verilog/dcc_pkg.sv
// package: register map, fields and types of the dual comparator control
package dcc_pkg;
  // ***************************
  // register offsets (byte addresses)
  // ***************************
  localparam logic [7:0] ctrl0_addr = 8'h00;
  localparam logic [7:0] ctrl1_addr = 8'h04;
  localparam logic [7:0] sel0_addr = 8'h08;
  localparam logic [7:0] sel1_addr = 8'h0c;
  localparam logic [7:0] pin_ctrl_addr = 8'h10;
  localparam logic [7:0] win_ctrl_addr = 8'h14;
  localparam logic [7:0] status_addr = 8'h18;
  localparam logic [7:0] irq_mask_addr = 8'h1c;
  localparam logic [7:0] irq_status_addr = 8'h20;
  // ***************************
  // reset values and codes
  // ***************************
  localparam logic [7:0] reg_reset = 8'h00;
  localparam logic [1:0] edge_toggle = 2'h0;
  localparam logic [1:0] edge_falling = 2'h2;
  localparam logic [1:0] edge_rising = 2'h3;
  localparam logic [1:0] win_above = 2'h0;
  localparam logic [1:0] win_inside = 2'h1;
  localparam logic [1:0] win_below = 2'h2;
  localparam logic [1:0] win_outside = 2'h3;
  localparam logic [2:0] pos_reserved = 3'h7;
  localparam logic [2:0] neg_reserved = 3'h5;
  localparam logic [1:0] hys_reserved = 2'h3;
  localparam int sync_stages = 2;

  typedef struct packed {
    logic [1:0] edge_trigger_select;
    logic [1:0] irq_priority_level;
    logic reserved;
    logic [1:0] hysteresis_select;
    logic enable;
  } dcc_ctrl_t;

  typedef struct packed {
    logic [1:0] reserved;
    logic [2:0] positive_input_select;
    logic [2:0] negative_input_select;
  } dcc_sel_t;

  typedef struct packed {
    logic [2:0] reserved;
    logic window_enable;
    logic [1:0] window_irq_condition;
    logic [1:0] window_irq_level;
  } dcc_win_t;

  // analog front end settings for one comparator
  typedef struct packed {
    logic enable;
    logic [1:0] hysteresis_select;
    logic [2:0] positive_input_select;
    logic [2:0] negative_input_select;
  } dcc_analog_t;
endpackage

// ===== verilog/dcc_sync.sv
// two flop synchroniser for one comparator output
`timescale 1ns/100ps
`default_nettype none
module dcc_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/dcc_edge.sv
// edge qualification of one synchronised comparator result
`timescale 1ns/100ps
`default_nettype none
module dcc_edge (
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic result,
  input wire logic [1:0] edge_trigger_select,
  output logic hit
);
  logic prev;
  logic rise;
  logic fall;
  // previous sample compared with current one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev <= 1'b0;
    end else begin
      prev <= result;
    end
  end
  assign rise = enable && result && !prev;
  assign fall = enable && !result && prev;
  always_comb begin
    case (edge_trigger_select)
      dcc_pkg::edge_toggle: hit = rise | fall;
      dcc_pkg::edge_falling: hit = fall;
      dcc_pkg::edge_rising: hit = rise;
      default: hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ===== verilog/dcc_top.sv
// dual comparator control: apb registers, events, window mode, pin drive
`timescale 1ns/100ps
`default_nettype none
module dcc_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] analog_result,
  input wire logic [2:0] irq_ack,
  output dcc_pkg::dcc_analog_t analog_zero,
  output dcc_pkg::dcc_analog_t analog_one,
  output logic [1:0] comparator_event,
  output logic window_event,
  output logic [2:0] irq_request,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic irq
);
  // ***************************
  // register state
  // ***************************
  dcc_pkg::dcc_ctrl_t ctrl [2];
  dcc_pkg::dcc_sel_t sel [2];
  dcc_pkg::dcc_win_t win;
  logic [1:0] pin_drive;
  logic [2:0] flags;
  logic [2:0] irq_mask;
  logic [2:0] irq_status;
  logic [1:0] window_current_state;
  logic [1:0] result;
  logic [1:0] hit;
  logic window_hit;
  logic [1:0] prev_window_state;
  logic window_valid;
  logic setup;
  logic wr;
  logic rd;
  logic mapped;
  logic [2:0] set_flags;
  logic [2:0] wr_clear;
  logic [2:0] next_flags;
  logic [2:0] next_irq_status;
  logic [7:0] status_byte;
  logic [7:0] read_byte;

  // ***************************
  // comparator result paths
  // ***************************
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_cmp
      logic raw_sync;
      dcc_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in(analog_result[g]),
        .sync_out(raw_sync)
      );
      // disabled comparator reads as zero
      assign result[g] = raw_sync & ctrl[g].enable;
      dcc_edge u_edge (
        .clk(clk),
        .rstn(rstn),
        .enable(ctrl[g].enable),
        .result(result[g]),
        .edge_trigger_select(ctrl[g].edge_trigger_select),
        .hit(hit[g])
      );
    end
  endgenerate

  // ***************************
  // window mode
  // ***************************
  // comparator zero is upper limit, comparator one lower limit
  always_comb begin
    if (!result[0]) begin
      window_current_state = dcc_pkg::win_above;
    end else if (result[1]) begin
      window_current_state = dcc_pkg::win_inside;
    end else begin
      window_current_state = dcc_pkg::win_below;
    end
  end
  assign window_valid = win.window_enable && ctrl[0].enable && ctrl[1].enable;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_window_state <= dcc_pkg::win_above;
    end else begin
      prev_window_state <= window_current_state;
    end
  end

  // event on entering the selected region
  always_comb begin
    logic now_in;
    logic was_in;
    now_in = 1'b0;
    was_in = 1'b0;
    case (win.window_irq_condition)
      dcc_pkg::win_above: begin
        now_in = window_current_state == dcc_pkg::win_above;
        was_in = prev_window_state == dcc_pkg::win_above;
      end
      dcc_pkg::win_inside: begin
        now_in = window_current_state == dcc_pkg::win_inside;
        was_in = prev_window_state == dcc_pkg::win_inside;
      end
      dcc_pkg::win_below: begin
        now_in = window_current_state == dcc_pkg::win_below;
        was_in = prev_window_state == dcc_pkg::win_below;
      end
      default: begin
        now_in = window_current_state != dcc_pkg::win_inside;
        was_in = prev_window_state != dcc_pkg::win_inside;
      end
    endcase
    window_hit = window_valid && now_in && !was_in;
  end

  // ***************************
  // apb decode
  // ***************************
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  always_comb begin
    case (paddr)
      dcc_pkg::ctrl0_addr, dcc_pkg::ctrl1_addr, dcc_pkg::sel0_addr,
      dcc_pkg::sel1_addr, dcc_pkg::pin_ctrl_addr, dcc_pkg::win_ctrl_addr,
      dcc_pkg::status_addr, dcc_pkg::irq_mask_addr,
      dcc_pkg::irq_status_addr: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // no wait state: answer in the first access cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !mapped;
    end
  end
  logic take_wr;
  logic take_rd;
  assign take_wr = wr && pready && mapped;
  assign take_rd = rd && pready && mapped;

  // ***************************
  // configuration registers
  // ***************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl[0] <= dcc_pkg::reg_reset;
      ctrl[1] <= dcc_pkg::reg_reset;
    end else if (take_wr && paddr == dcc_pkg::ctrl0_addr) begin
      // reserved bit stays zero
      ctrl[0] <= pwdata[7:0] & 8'hf7;
    end else if (take_wr && paddr == dcc_pkg::ctrl1_addr) begin
      ctrl[1] <= pwdata[7:0] & 8'hf7;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel[0] <= dcc_pkg::reg_reset;
      sel[1] <= dcc_pkg::reg_reset;
    end else if (take_wr && paddr == dcc_pkg::sel0_addr) begin
      // reserved bits stay zero
      sel[0] <= pwdata[7:0] & 8'h3f;
    end else if (take_wr && paddr == dcc_pkg::sel1_addr) begin
      sel[1] <= pwdata[7:0] & 8'h3f;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      win <= dcc_pkg::reg_reset;
    end else if (take_wr && paddr == dcc_pkg::win_ctrl_addr) begin
      win <= pwdata[7:0] & 8'h1f;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_drive <= 2'h0;
    end else if (take_wr && paddr == dcc_pkg::pin_ctrl_addr) begin
      pin_drive <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= 3'h0;
    end else if (take_wr && paddr == dcc_pkg::irq_mask_addr) begin
      irq_mask <= pwdata[2:0];
    end
  end

  // ***************************
  // flags and events
  // ***************************
  assign set_flags = {window_hit, hit[1], hit[0]};
  assign wr_clear = (take_wr && paddr == dcc_pkg::status_addr) ? pwdata[2:0] : 3'h0;
  // set wins over clear
  assign next_flags = set_flags | (flags & ~wr_clear & ~irq_ack);
  assign next_irq_status = set_flags |
    ((take_rd && paddr == dcc_pkg::irq_status_addr) ? 3'h0 : irq_status);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags <= 3'h0;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      comparator_event <= 2'h0;
      window_event <= 1'b0;
    end else begin
      comparator_event <= hit;
      window_event <= window_hit;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_request <= 3'h0;
    end else begin
      irq_request <= next_flags & {win.window_irq_level != 2'h0,
        ctrl[1].irq_priority_level != 2'h0,
        ctrl[0].irq_priority_level != 2'h0};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // ***************************
  // analog settings and pins
  // ***************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      analog_zero <= '0;
      analog_one <= '0;
    end else begin
      analog_zero <= {ctrl[0].enable, ctrl[0].hysteresis_select,
        sel[0].positive_input_select, sel[0].negative_input_select};
      analog_one <= {ctrl[1].enable, ctrl[1].hysteresis_select,
        sel[1].positive_input_select, sel[1].negative_input_select};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_out <= 2'h0;
      pin_oe <= 2'h0;
    end else begin
      // bit 0 is pin 7, bit 1 is pin 6
      pin_out <= result;
      pin_oe <= pin_drive;
    end
  end

  // ***************************
  // read data
  // ***************************
  assign status_byte = {window_valid ? window_current_state : dcc_pkg::win_above,
    result[1], result[0], 1'b0, flags};
  always_comb begin
    case (paddr)
      dcc_pkg::ctrl0_addr: read_byte = ctrl[0];
      dcc_pkg::ctrl1_addr: read_byte = ctrl[1];
      dcc_pkg::sel0_addr: read_byte = sel[0];
      dcc_pkg::sel1_addr: read_byte = sel[1];
      dcc_pkg::pin_ctrl_addr: read_byte = {6'h00, pin_drive};
      dcc_pkg::win_ctrl_addr: read_byte = win;
      dcc_pkg::status_addr: read_byte = status_byte;
      dcc_pkg::irq_mask_addr: read_byte = {5'h00, irq_mask};
      dcc_pkg::irq_status_addr: read_byte = {5'h00, irq_status};
      default: read_byte = 8'h00;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0;
    end else if (setup) begin
      prdata <= {24'h0, read_byte};
    end
  end
endmodule
`default_nettype wire

// ===== bench/dcc_properties.sv
// port checker of the dual comparator control
`timescale 1ns/100ps
`default_nettype none
module dcc_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] analog_result,
  input wire logic [2:0] irq_ack,
  input wire dcc_pkg::dcc_analog_t analog_zero,
  input wire logic [1:0] comparator_event,
  input wire logic [2:0] irq_request
);
  logic [31:0] wd1;
  logic [31:0] wd2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge clk) begin
    wd1 <= pwdata;
    wd2 <= wd1;
  end
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("ready missing");
  chk_ready_once: assert property (pready |=> !pready) else $error("ready held");
  chk_err_unmap: assert property (pready && paddr > 8'h20 |-> pslverr)
    else $error("no error");
  chk_ctrl_store: assert property (pready && pwrite && paddr == 8'h00 |-> ##2
    analog_zero.enable == wd2[0] && analog_zero.hysteresis_select == wd2[2:1])
    else $error("control not applied");
  chk_sel_store: assert property (pready && pwrite && paddr == 8'h08 |-> ##2
    {analog_zero.positive_input_select, analog_zero.negative_input_select} == wd2[5:0])
    else $error("select not applied");
  chk_event_once: assert property (comparator_event[0] |=> !comparator_event[0])
    else $error("event held");
  chk_event_cause: assert property ($stable(analog_result[0]) [*8] |-> !comparator_event[0])
    else $error("event without edge");
  chk_off_quiet: assert property (!analog_zero.enable [*6] |-> !comparator_event[0])
    else $error("event while off");
  chk_ack_clear: assert property ((irq_ack[0] && !comparator_event[0]) [*3] |->
    !irq_request[0]) else $error("ack ignored");
endmodule
bind dcc_top dcc_properties chk (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .analog_result, .irq_ack, .analog_zero, .comparator_event, .irq_request);
`default_nettype wire

// ===== bench/dcc_afe_model.sv
// behavioural analog front end: levels of pins 0-7, bandgap, scaler
`timescale 1ns/100ps
`default_nettype none
module dcc_afe_model (
  input wire logic [79:0] volts,
  input wire dcc_pkg::dcc_analog_t analog_zero,
  input wire dcc_pkg::dcc_analog_t analog_one,
  output logic [1:0] analog_result
);
  function automatic logic cmp(input dcc_pkg::dcc_analog_t a, input logic [79:0] v);
    logic [3:0] n;
    case (a.negative_input_select)
      3'h2: n = 4'h3;
      3'h3: n = 4'h5;
      3'h4: n = 4'h7;
      3'h6: n = 4'h8;
      3'h7: n = 4'h9;
      default: n = {1'b0, a.negative_input_select};
    endcase
    return a.enable && (v[{a.positive_input_select, 3'h0} +: 8] > v[{n, 3'h0} +: 8]);
  endfunction
  assign analog_result = {cmp(analog_one, volts), cmp(analog_zero, volts)};
endmodule
`default_nettype wire

// ===== bench/dual_comparator_control_bench.sv
// self-checking bench of the dual comparator control
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, a); end end
module dual_comparator_control_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] irq_ack = 3'h0;
  logic [79:0] volts = 80'h0;
  logic [31:0] prdata;
  logic pready, pslverr, window_event, irq;
  logic [1:0] analog_result, comparator_event, pin_out, pin_oe;
  logic [2:0] irq_request;
  dcc_pkg::dcc_analog_t analog_zero, analog_one;
  int errors = 0;
  int checks_done = 0;
  int ev0 = 0;
  int wev = 0;
  logic [32:0] notes[$];
  logic [32:0] exp_rd;
  logic [31:0] d;
  logic [2:0] p;
  logic e;
  localparam logic [7:0] rw_addr [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
  localparam logic [7:0] rw_mask [7] = '{8'hf7, 8'hf7, 8'h3f, 8'h3f, 8'h03, 8'h1f, 8'h07};
  localparam logic [2:0] ncode [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  localparam int nmap [7] = '{0, 1, 3, 5, 7, 8, 9};
  localparam logic [1:0] emode [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  localparam int ecount [4] = '{2, 1, 1, 0};
  localparam int wexp [4] = '{1, 2, 1, 2};
  localparam logic [7:0] wpath [4] = '{8'hc8, 8'h64, 8'h0a, 8'h64};
  dcc_top dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .analog_result, .irq_ack, .analog_zero, .analog_one, .comparator_event,
    .window_event, .irq_request, .pin_out, .pin_oe, .irq);
  dcc_afe_model afe (.volts, .analog_zero, .analog_one, .analog_result);
  initial forever #12.5 clk = ~clk;
  initial begin
    #1000000;
    errors++;
    stop_test();
  end
  always @(posedge clk) begin
    if (comparator_event[0]) ev0++;
    if (window_event) wev++;
    if (psel && penable && pready && !pwrite && notes.size() > 0) begin
      exp_rd = notes.pop_front();
      `CHK("read", exp_rd, {pslverr, prdata})
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 20);
    if (n >= 20) begin
      errors++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    notes.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic lv(input int i, input logic [7:0] v);
    volts[i * 8 +: 8] <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ***************
  // scenarios
  // ***************
  initial begin
    void'($urandom(32'hb763));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    foreach (rw_addr[i]) rd(rw_addr[i], 33'h0);
    rd(8'h24, {1'b1, 32'h0});
    foreach (rw_addr[i]) begin
      d = $urandom;
      apb(1'b1, rw_addr[i], d);
      rd(rw_addr[i], {25'h0, d[7:0] & rw_mask[i]});
      apb(1'b1, rw_addr[i], 32'h0);
    end
    apb(1'b1, 8'h24, 32'hff);
    rd(8'h24, {1'b1, 32'h0});
    apb(1'b1, 8'h18, 32'h07);
    apb(1'b1, 8'h10, 32'h3);
    foreach (ncode[i]) begin
      p = 3'($urandom_range(6));
      apb(1'b1, 8'h08, {26'h0, p, ncode[i]});
      apb(1'b1, 8'h0c, {26'h0, p, ncode[i]});
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h04, 32'h1);
      volts <= 80'({$urandom, $urandom, $urandom});
      repeat (8) @(posedge clk);
      e = volts[p * 8 +: 8] > volts[nmap[i] * 8 +: 8];
      `CHK("result", {e, e}, pin_out)
      `CHK("drive", 2'h3, pin_oe)
    end
    apb(1'b1, 8'h08, 32'h01);
    lv(1, 8'h64);
    lv(0, 8'h32);
    foreach (emode[i]) begin
      apb(1'b1, 8'h00, {24'h0, emode[i], 6'h01});
      lv(0, 8'h32);
      ev0 = 0;
      lv(0, 8'hc8);
      lv(0, 8'h32);
      `CHK("events", ecount[i], ev0)
    end
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    apb(1'b1, 8'h1c, 32'h1);
    apb(1'b1, 8'h18, 32'h07);
    apb(1'b1, 8'h00, 32'hd1);
    lv(0, 8'hc8);
    `CHK("request", 1'b1, irq_request[0])
    `CHK("irq", 1'b1, irq)
    rd(8'h20, {25'h0, 8'h01});
    `CHK("irq", 1'b0, irq)
    irq_ack <= 3'h1;
    repeat (3) @(posedge clk);
    irq_ack <= 3'h0;
    lv(0, 8'h32);
    `CHK("request", 1'b0, irq_request[0])
    lv(0, 8'hc8);
    apb(1'b1, 8'h18, 32'h01);
    lv(0, 8'hc8);
    `CHK("request", 1'b0, irq_request[0])
    apb(1'b1, 8'h08, 32'h08);
    apb(1'b1, 8'h0c, 32'h02);
    apb(1'b1, 8'h04, 32'h1);
    lv(1, 8'h96);
    lv(3, 8'h32);
    for (int c = 0; c < 4; c++) begin
      lv(0, 8'h64);
      apb(1'b1, 8'h14, {26'h0, 2'h1, 2'(c), 2'h1});
      lv(0, 8'h64);
      wev = 0;
      foreach (wpath[j]) lv(0, wpath[j]);
      `CHK("window", wexp[c], wev)
    end
    `CHK("request", 1'b1, irq_request[2])
    stop_test();
  end
endmodule
`default_nettype wire
